/* src/mem_cfg_pkg.sv */
// Register map, field layout and carrier types of the memory check config
package mem_cfg_pkg;

   // Register byte offsets on the APB bus
   localparam logic [7:0] OFF_MCC2 = 8'h00;
   localparam logic [7:0] OFF_AUX = 8'h04;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h08;
   localparam logic [7:0] OFF_IRQ_CLEAR = 8'h0C;
   localparam logic [7:0] OFF_IRQ_ENABLE = 8'h10;

   // Field positions of memory_control_config_two
   localparam int POS_INLINE_PAR = 20;
   localparam int POS_INLINE_RD = 18;
   localparam int POS_ECC_EN = 17;
   localparam int POS_EDO = 16;
   localparam int POS_REFRESH_LO = 2;
   localparam int REFRESH_W = 14;
   localparam int POS_RESERVE = 1;
   localparam int POS_RMW = 0;

   // Field positions of the auxiliary check register
   localparam int POS_PAR_CHECK = 0;
   localparam int POS_BUF_LO = 1;
   localparam logic [1:0] BUF_INLINE = 2'h2;

   // Interrupt status bit positions
   localparam int ST_REFRESH = 0;
   localparam int ST_INLINE_ERR = 1;
   localparam int ST_LEGACY_ERR = 2;
   localparam int ST_W = 3;

   // Reset values and page limits
   localparam logic [REFRESH_W-1:0] REFRESH_RESET = 14'h0000;
   localparam logic [ST_W-1:0] ST_RESET = 3'h0;
   localparam logic [2:0] PAGES_ALL = 3'h4;
   localparam logic [2:0] PAGES_RESERVED = 3'h3;

   // Software view of the configuration fields
   typedef struct packed {
      logic inline_parity_select;
      logic inline_read_check_enable;
      logic ecc_enable;
      logic edo_select;
      logic [REFRESH_W-1:0] refresh_interval;
      logic reserve_page_register;
      logic read_modify_write_parity;
      logic parity_check_enable;
      logic [1:0] buffer_type;
   } cfg_t;

   localparam cfg_t CFG_RESET = '{default: 1'b0};

   // Effective modes handed to the memory datapath
   typedef struct packed {
      logic inline_ecc;
      logic inline_parity;
      logic legacy_ecc;
      logic legacy_parity;
      logic edo_mode;
      logic rmw_parity_write;
      logic [2:0] open_page_limit;
   } mode_t;

   // Register word of the configuration fields held in one register
   function automatic logic [31:0] mcc2_word(input cfg_t c);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[POS_INLINE_PAR] = c.inline_parity_select;
      w[POS_INLINE_RD] = c.inline_read_check_enable;
      w[POS_ECC_EN] = c.ecc_enable;
      w[POS_EDO] = c.edo_select;
      w[POS_REFRESH_LO +: REFRESH_W] = c.refresh_interval;
      w[POS_RESERVE] = c.reserve_page_register;
      w[POS_RMW] = c.read_modify_write_parity;
      return w;
   endfunction

   // Register word of the auxiliary check fields
   function automatic logic [31:0] aux_word(input cfg_t c);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[POS_PAR_CHECK] = c.parity_check_enable;
      w[POS_BUF_LO +: 2] = c.buffer_type;
      return w;
   endfunction

endpackage

/* src/refresh_timer.sv */
// CBR refresh interval timer
`timescale 1ns/1ps
module refresh_timer
   import mem_cfg_pkg::*;
#(
   parameter int CNT_W = REFRESH_W
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [CNT_W-1:0] interval,
   output logic tick
);

   // Elaboration check: the counter compare needs a sane width
   if (CNT_W < 2 || CNT_W > 31) begin : g_bad_width
      $error("refresh_timer: CNT_W out of range");
   end

   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic tick_q, tick_d;

   // A zero interval stops refresh; >= lets a shortened interval act at once
   always_comb begin
      tick_d = 1'b0;
      cnt_d = cnt_q + 1'b1;
      if (interval == '0) begin
         cnt_d = '0;
      end else if (cnt_q >= interval - 1'b1) begin
         tick_d = 1'b1;
         cnt_d = '0;
      end
   end

   // Counter and tick registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;

endmodule // refresh_timer

/* src/memory_check_refresh_config.sv */
// Memory check, DRAM type and refresh configuration slice with APB slave
`timescale 1ns/1ps
module memory_check_refresh_config
   import mem_cfg_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic inline_err_in,
   input wire logic legacy_err_in,
   output mode_t mode,
   output logic refresh_req,
   output logic irq
);

   // Reset release through two flops; assertion stays asynchronous
   logic [1:0] rst_sync_q;
   logic rst_n;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_q[1];

   // ------------------------------------------------------------------
   // APB slave: zero wait states, answer registered in the setup cycle
   // ------------------------------------------------------------------
   logic setup_phase;
   logic access_done;
   logic wr_en;
   logic addr_ok;
   logic [31:0] rdata_mux;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;

   assign setup_phase = psel & ~penable;
   assign access_done = psel & penable & pready_q;
   assign wr_en = access_done & pwrite & ~pslverr_q;

   cfg_t cfg_q, cfg_d;
   logic [ST_W-1:0] status_q, status_d;
   logic [ST_W-1:0] enable_q, enable_d;

   // Address decode and read mux; the clear register reads as zero
   always_comb begin
      addr_ok = 1'b1;
      rdata_mux = 32'h0000_0000;
      unique case (paddr)
         OFF_MCC2: rdata_mux = mcc2_word(cfg_q);
         OFF_AUX: rdata_mux = aux_word(cfg_q);
         OFF_IRQ_STATUS: rdata_mux[ST_W-1:0] = status_q;
         OFF_IRQ_CLEAR: rdata_mux = 32'h0000_0000;
         OFF_IRQ_ENABLE: rdata_mux[ST_W-1:0] = enable_q;
         default: addr_ok = 1'b0;
      endcase
   end

   // Answer computed in setup so outputs come straight from flops
   always_comb begin
      prdata_d = 32'h0000_0000;
      pslverr_d = 1'b0;
      pready_d = setup_phase;
      if (setup_phase) begin
         prdata_d = pwrite ? 32'h0000_0000 : rdata_mux;
         pslverr_d = ~addr_ok;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // ------------------------------------------------------------------
   // Configuration fields: written only at the completing access edge
   // ------------------------------------------------------------------
   always_comb begin
      cfg_d = cfg_q;
      if (wr_en && paddr == OFF_MCC2) begin
         cfg_d.inline_parity_select = pwdata[POS_INLINE_PAR];
         cfg_d.inline_read_check_enable = pwdata[POS_INLINE_RD];
         cfg_d.ecc_enable = pwdata[POS_ECC_EN];
         cfg_d.edo_select = pwdata[POS_EDO];
         cfg_d.refresh_interval = pwdata[POS_REFRESH_LO +: REFRESH_W];
         cfg_d.reserve_page_register = pwdata[POS_RESERVE];
         cfg_d.read_modify_write_parity = pwdata[POS_RMW];
      end
      if (wr_en && paddr == OFF_AUX) begin
         cfg_d.parity_check_enable = pwdata[POS_PAR_CHECK];
         cfg_d.buffer_type = pwdata[POS_BUF_LO +: 2];
      end
   end

   // Illegal software combinations are stored as written, not repaired
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= CFG_RESET;
      end else begin
         cfg_q <= cfg_d;
      end
   end

   // ------------------------------------------------------------------
   // Effective modes for the memory datapath
   // ------------------------------------------------------------------
   mode_t mode_q, mode_d;
   logic inline_on;

   // In-line and legacy checkers are decoded independently of each other
   always_comb begin
      inline_on = cfg_q.inline_read_check_enable
                  && cfg_q.buffer_type == BUF_INLINE;
      mode_d.inline_ecc = inline_on
                          & ~cfg_q.inline_parity_select;
      mode_d.inline_parity = inline_on
                             & cfg_q.inline_parity_select;
      mode_d.legacy_ecc = cfg_q.ecc_enable;
      mode_d.legacy_parity = cfg_q.parity_check_enable
                             & ~cfg_q.ecc_enable;
      mode_d.edo_mode = cfg_q.edo_select;
      mode_d.rmw_parity_write = cfg_q.read_modify_write_parity;
      mode_d.open_page_limit = cfg_q.reserve_page_register
                               ? PAGES_RESERVED : PAGES_ALL;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= '{open_page_limit: PAGES_ALL, default: 1'b0};
      end else begin
         mode_q <= mode_d;
      end
   end

   // ------------------------------------------------------------------
   // CBR refresh: one request refreshes a row in every bank at once
   // ------------------------------------------------------------------
   logic refresh_tick;
   logic refresh_q, refresh_d;

   refresh_timer #(
      .CNT_W(REFRESH_W)
   ) u_refresh_timer (
      .mclk(mclk),
      .rst_n(rst_n),
      .interval(cfg_q.refresh_interval),
      .tick(refresh_tick)
   );

   assign refresh_d = refresh_tick;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         refresh_q <= 1'b0;
      end else begin
         refresh_q <= refresh_d;
      end
   end

   // ------------------------------------------------------------------
   // Interrupts: sticky status, write-one clear, enable mask
   // ------------------------------------------------------------------
   logic [ST_W-1:0] events;
   logic irq_q, irq_d;

   // Errors count only when the matching checker is switched on
   always_comb begin
      events = ST_RESET;
      events[ST_REFRESH] = refresh_q;
      events[ST_INLINE_ERR] = inline_err_in
         & (mode_q.inline_ecc | mode_q.inline_parity);
      events[ST_LEGACY_ERR] = legacy_err_in
         & (mode_q.legacy_ecc | mode_q.legacy_parity);
   end

   // A new event in the clearing cycle wins so no event is lost
   always_comb begin
      status_d = status_q;
      enable_d = enable_q;
      if (wr_en && paddr == OFF_IRQ_CLEAR) begin
         status_d = status_q & ~pwdata[ST_W-1:0];
      end
      status_d = status_d | events;
      if (wr_en && paddr == OFF_IRQ_ENABLE) begin
         enable_d = pwdata[ST_W-1:0];
      end
      irq_d = |(status_d & enable_d);
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         status_q <= ST_RESET;
         enable_q <= ST_RESET;
         irq_q <= 1'b0;
      end else begin
         status_q <= status_d;
         enable_q <= enable_d;
         irq_q <= irq_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign mode = mode_q;
   assign refresh_req = refresh_q;
   assign irq = irq_q;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   // Helper: cycles since the last refresh and whether the whole configuration held
   logic [REFRESH_W:0] gap_q;
   logic steady_q;
   logic seen_q;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         gap_q <= '0;
         steady_q <= 1'b0;
         seen_q <= 1'b0;
      end else begin
         gap_q <= refresh_q ? {{REFRESH_W{1'b0}}, 1'b1} : gap_q + 1'b1;
         steady_q <= refresh_q | (steady_q & (cfg_d == cfg_q));
         seen_q <= seen_q | refresh_q;
      end
   end

   AST_INLINE_NEEDS_BUFFER: assert property (
      (mode_q.inline_ecc | mode_q.inline_parity) |->
         $past(cfg_q.inline_read_check_enable)
         && $past(cfg_q.buffer_type) == BUF_INLINE)
      else $error("in-line check active without enable or in-line buffer");

   AST_INLINE_SELECT: assert property (
      inline_on |=>
         mode_q.inline_parity == $past(cfg_q.inline_parity_select)
         && mode_q.inline_ecc == !$past(cfg_q.inline_parity_select))
      else $error("in-line parity/ECC select not followed");

   AST_INLINE_ERR_REPORT: assert property (
      (inline_err_in && !mode_q.inline_ecc && !mode_q.inline_parity
       && !status_q[ST_INLINE_ERR]) |=> !status_q[ST_INLINE_ERR])
      else $error("in-line error reported while checking disabled");

   AST_LEGACY_SEPARATE: assert property (
      (cfg_q.ecc_enable && cfg_q.parity_check_enable) |=>
         mode_q.legacy_ecc && !mode_q.legacy_parity)
      else $error("legacy ECC did not override parity check");

   AST_DRAM_TYPE: assert property (
      $rose(cfg_q.edo_select) |=> mode_q.edo_mode)
      else $error("EDO selection not applied");

   AST_REFRESH_SPACING: assert property (
      (refresh_q && seen_q && steady_q) |->
         gap_q == {1'b0, cfg_q.refresh_interval})
      else $error("refresh spacing differs from programmed interval");

   AST_REFRESH_OFF: assert property (
      (cfg_q.refresh_interval == '0
       && $past(cfg_q.refresh_interval) == '0
       && $past(cfg_q.refresh_interval, 2) == '0) |-> !refresh_q)
      else $error("refresh issued with zero interval");

   AST_PAGE_LIMIT: assert property (
      cfg_q.reserve_page_register |=> mode_q.open_page_limit == PAGES_RESERVED
         || !cfg_q.reserve_page_register)
      else $error("reserved page not honoured");

   AST_RMW_NO_CHECK: assert property (
      (cfg_q.read_modify_write_parity && !cfg_q.parity_check_enable) |=>
         !mode_q.legacy_parity)
      else $error("RMW parity bit enabled parity checking");

   AST_RESET_ZERO: assert property (
      $rose(rst_n) |-> cfg_q == CFG_RESET && mode_q.open_page_limit == PAGES_ALL)
      else $error("configuration not zero after reset");

   AST_WRITE_READBACK: assert property (
      (wr_en && paddr == OFF_MCC2) |=>
         mcc2_word(cfg_q) == ($past(pwdata) & mcc2_word('1)))
      else $error("configuration write not stored");

   AST_IRQ_LEVEL: assert property (
      ##1 irq_q == |(status_q & enable_q))
      else $error("interrupt level disagrees with status and enable");

endmodule // memory_check_refresh_config

/* testbench/mem_side_model.sv */
// Memory-side model: error reporters and a per-bank refresh row tracker
`timescale 1ns/1ps
module mem_side_model (
   input wire logic mclk,
   input wire logic refresh_req,
   input wire logic fire_inline,
   input wire logic fire_legacy,
   output logic inline_err_in,
   output logic legacy_err_in,
   output int refresh_count
);
   localparam int BANKS = 4;
   localparam int ROWS = 16;
   int row_q [BANKS];

   // Quiet lines and first rows until the bench asks for anything
   initial begin
      inline_err_in = 1'b0;
      legacy_err_in = 1'b0;
      refresh_count = 0;
      foreach (row_q[b]) row_q[b] = 0;
   end

   // Checkers flag a one-cycle error only when the bench orders one
   always @(posedge mclk) begin
      inline_err_in <= fire_inline;
      legacy_err_in <= fire_legacy;
   end

   // Each refresh pulse steps one row in every bank
   always @(posedge mclk) begin
      if (refresh_req === 1'b1) begin
         refresh_count <= refresh_count + 1;
         foreach (row_q[b]) row_q[b] <= (row_q[b] + 1) % ROWS;
      end
   end
endmodule // mem_side_model

/* testbench/memory_check_refresh_config_test.sv */
// Self-checking bench for the memory check and refresh config slice
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module memory_check_refresh_config_test
   import mem_cfg_pkg::*;
();
   localparam logic [31:0] CFG_MASK = 32'h0017_FFFF;
   logic mclk = 1'b0;
   logic resetn, psel, penable, pwrite, pready, pslverr, irq;
   logic inline_err_in, legacy_err_in, refresh_req, fire_inline, fire_legacy;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, c, a, r;
   logic [31:0] seed = 32'h0000_8EF7;
   logic [32:0] e_m, m_m;
   logic [32:0] exp_q[$];
   logic [32:0] msk_q[$];
   mode_t mode;
   int errors, n_tests, refresh_count, n, c0;

   always #50 mclk = ~mclk;

   memory_check_refresh_config dut_u (.mclk(mclk), .resetn(resetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .inline_err_in(inline_err_in), .legacy_err_in(legacy_err_in),
      .mode(mode), .refresh_req(refresh_req), .irq(irq));

   mem_side_model model_u (.mclk(mclk), .refresh_req(refresh_req),
      .fire_inline(fire_inline), .fire_legacy(fire_legacy),
      .inline_err_in(inline_err_in), .legacy_err_in(legacy_err_in),
      .refresh_count(refresh_count));

   // Fixed-seed xorshift keeps every run identical
   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Datapath modes the config and aux words should produce
   function mode_t exp_mode(input logic [31:0] cw, input logic [31:0] aw);
      mode_t m;
      logic inl;
      inl = cw[18] && (aw[2:1] == BUF_INLINE);
      m.inline_ecc = inl && !cw[20];
      m.inline_parity = inl && cw[20];
      m.legacy_ecc = cw[17];
      m.legacy_parity = aw[0] && !cw[17];
      m.edo_mode = cw[16];
      m.rmw_parity_write = cw[0];
      m.open_page_limit = cw[1] ? PAGES_RESERVED : PAGES_ALL;
      return m;
   endfunction

   task tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // One APB transfer; the expected answer waits in the queue
   task apb(input logic wr, input logic [7:0] ad, input logic [31:0] d,
            input logic [32:0] e, input logic [32:0] m);
      int k;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= d;
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      @(posedge mclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         errors++;
         $display("[FAIL] apb ready timeout");
         tally_and_finish;
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [7:0] ad, input logic [31:0] d);
      apb(1'b1, ad, d, 33'h0_0000_0000, 33'h1_0000_0000);
   endtask

   task rd(input logic [7:0] ad, input logic [31:0] d);
      apb(1'b0, ad, 32'h0000_0000, {1'b0, d}, 33'h1_FFFF_FFFF);
   endtask

   // Count edges up to the next refresh pulse, bounded
   task wait_refresh(output int cnt);
      cnt = 0;
      do begin
         @(posedge mclk);
         cnt++;
      end while (refresh_req !== 1'b1 && cnt < 60);
      if (refresh_req !== 1'b1) begin
         errors++;
         $display("[FAIL] refresh wait timeout");
         tally_and_finish;
      end
   endtask

   task settle;
      repeat (3) @(posedge mclk);
      #1;
   endtask

   // One error report from the memory side, then let status land
   task pulse(input logic inl);
      @(posedge mclk);
      if (inl) fire_inline <= 1'b1;
      else fire_legacy <= 1'b1;
      @(posedge mclk);
      fire_inline <= 1'b0;
      fire_legacy <= 1'b0;
      settle;
   endtask

   // Monitor: every completed transfer is judged against the oldest note
   always @(posedge mclk) begin
      if (psel && penable && pready === 1'b1) begin
         if (exp_q.size() == 0) begin
            errors++;
            $display("[FAIL] apb answer with no note");
         end else begin
            e_m = exp_q.pop_front();
            m_m = msk_q.pop_front();
            `CHK("apb answer", e_m, {pslverr, prdata} & m_m)
         end
      end
   end

   // Hang guard at 60000 cycles, far above the run length
   initial begin
      #6000000;
      errors++;
      $display("[FAIL] run watchdog");
      tally_and_finish;
   end

   initial begin
      resetn = 1'b0;
      {psel, penable, pwrite, fire_inline, fire_legacy} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      errors = 0;
      n_tests = 0;
      repeat (6) @(posedge mclk);
      resetn <= 1'b1;
      repeat (6) @(posedge mclk);
      #1;
      `CHK("mode at reset", exp_mode(0, 0), mode)
      rd(OFF_MCC2, 32'h0000_0000);
      rd(OFF_AUX, 32'h0000_0000);
      // Walk check modes under legal software settings
      for (int i = 0; i < 16; i++) begin
         c = xs();
         r = xs();
         c[15] = 1'b1;
         c[18] = i[0];
         c[20] = i[1];
         c[17] = i[3] && !i[2];
         c[0] = c[17] ? 1'b0 : (c[18] && i[2] && !i[1]) | c[0];
         a = r;
         a[2:1] = i[2] ? BUF_INLINE : {1'b0, r[1]};
         a[0] = r[0] && !c[18];
         wr(OFF_MCC2, c);
         wr(OFF_AUX, a);
         rd(OFF_MCC2, c & CFG_MASK);
         rd(OFF_AUX, a & 32'h0000_0007);
         #1;
         `CHK("mode", exp_mode(c, a), mode)
      end
      apb(1'b1, 8'h20, xs(), 33'h1_0000_0000, 33'h1_FFFF_FFFF);
      apb(1'b0, 8'h20, 32'h0, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
      // Refresh every five cycles, then stopped by a zero interval
      wr(OFF_MCC2, 32'h0000_0014);
      wait_refresh(n);
      wait_refresh(n);
      `CHK("refresh gap", 5, n)
      #1;
      c0 = refresh_count;
      repeat (20) @(posedge mclk);
      #1;
      `CHK("refresh count", 4, refresh_count - c0)
      wr(OFF_MCC2, 32'h0000_0000);
      settle;
      c0 = refresh_count;
      repeat (30) @(posedge mclk);
      #1;
      `CHK("refresh stopped", 0, refresh_count - c0)
      rd(OFF_IRQ_STATUS, 32'h0000_0001);
      wr(OFF_IRQ_STATUS, 32'h0000_0000);
      wr(OFF_IRQ_CLEAR, 32'h0000_0007);
      rd(OFF_IRQ_STATUS, 32'h0000_0000);
      rd(OFF_IRQ_CLEAR, 32'h0000_0000);
      // Legacy errors are dropped while legacy checking is off; in-line errors count while in-line checking is on
      wr(OFF_IRQ_ENABLE, 32'h0000_0006);
      wr(OFF_AUX, 32'h0000_0004);
      wr(OFF_MCC2, 32'h0004_0001);
      pulse(1'b0);
      `CHK("irq idle", 1'b0, irq)
      pulse(1'b1);
      rd(OFF_IRQ_STATUS, 32'h0000_0002);
      `CHK("irq inline", 1'b1, irq)
      wr(OFF_IRQ_ENABLE, 32'h0000_0000);
      settle;
      `CHK("irq masked", 1'b0, irq)
      wr(OFF_IRQ_ENABLE, 32'h0000_0006);
      wr(OFF_IRQ_CLEAR, 32'h0000_0002);
      settle;
      `CHK("irq cleared", 1'b0, irq)
      // Legacy ECC on, in-line off: only the legacy checker counts
      wr(OFF_MCC2, 32'h0002_0000);
      pulse(1'b1);
      pulse(1'b0);
      rd(OFF_IRQ_STATUS, 32'h0000_0004);
      `CHK("irq legacy", 1'b1, irq)
      tally_and_finish;
   end
endmodule // memory_check_refresh_config_test
